/* fault_mgr_defines.svh */
// register offsets, reset values and timing counts of the fault manager
`ifndef FAULT_MGR_DEFINES_SVH
`define FAULT_MGR_DEFINES_SVH
`define REG_STATE_POS      4'h0
`define REG_IRQ_CAUSE1     4'h1
`define REG_IRQ_CAUSE2     4'h2
`define REG_STATUS_FLAGS   4'h3
`define REG_RESERVED       4'h4
`define REG_COMMAND        4'h5
`define REG_IRQ_MASK1      4'h6
`define REG_IRQ_MASK2      4'h7
`define REG_CONFIG1        4'h8
`define REG_CONFIG2        4'h9
`define REG_VOUT_HIGH      4'hA
`define REG_VOUT_LOW       4'hB
`define REG_CURRENT_LIMIT_CODE           4'hC
`define REG_AUX_LDO        4'hD
`define REG_CONFIG4        4'hE
`define REG_CONFIG5        4'hF
`define RST_COMMAND        8'h00
`define RST_IRQ_MASK1      8'h00
`define RST_IRQ_MASK2      8'h00
`define RST_CONFIG1        8'h28
`define RST_CONFIG2        8'hF3
`define RST_VOUT_HIGH      8'h32
`define RST_VOUT_LOW       8'h10
`define RST_CURRENT_LIMIT_CODE           8'hFF
`define RST_AUX_LDO        8'h30
`define RST_CONFIG4        8'h23
`define RST_CONFIG5        8'h9E
`define CFG2_UV_LATCH_BIT  2
`define CAUSE1_RFREQ_BIT   4
`define CAUSE1_SOFT_TSD    2
`define CAUSE1_HARD_TSD    3
`define CAUSE1_SYNC_BIT    5
`define CAUSE1_INPUT_OVERVOLTAGE_LOCKOUT_BIT    0
`define CAUSE2_OCP_BIT     6
`define CAUSE2_OVP_BIT     5
`define CAUSE2_UVP_BIT     4
`define CAUSE2_LDO_UV_BIT  3
`define CAUSE2_MB_OC_BIT   2
`define CAUSE2_MB_OV_BIT   1
`define CAUSE2_MB_UV_BIT   0
`define OCP_PAIR_COUNT     3'd4
`define RESET_BLANK_US     10
`define HICCUP_WAIT_US     1000
`define CLK_PERIOD_NS      5
`define RESET_BLANK_CYC    (`RESET_BLANK_US * 1000 / `CLK_PERIOD_NS)
`define HICCUP_WAIT_CYC    (`HICCUP_WAIT_US * 1000 / `CLK_PERIOD_NS)
`endif

/* fault_mgr_pkg.sv */
// types shared by the fault manager
package fault_mgr_pkg;
  typedef enum logic [3:0] {
    ST_NO_POWER    = 4'b0000,
    ST_BIAS_INIT   = 4'b0001,
    ST_BIAS_RESET  = 4'b0010,
    ST_BIAS_ADDR   = 4'b0011,
    ST_BIAS_RAMP   = 4'b0100,
    ST_RFREQ_CHECK = 4'b0101,
    ST_RFREQ_LOOP  = 4'b0110,
    ST_BIAS_READY  = 4'b0111,
    ST_MAIN_EN     = 4'b1000,
    ST_MAIN_RAMP   = 4'b1001,
    ST_MAIN_ON     = 4'b1010,
    ST_MAIN_SHUT   = 4'b1011,
    ST_MAIN_ERROR  = 4'b1100
  } sm_state_t;
  // fault detector inputs, all levels
  typedef struct packed {
    logic input_undervoltage_lockout;
    logic input_overvoltage_lockout;
    logic mini_overcurrent;
    logic mini_overvoltage;
    logic mini_undervoltage;
    logic aux_ldo_undervoltage;
    logic hard_thermal_shutdown;
    logic soft_thermal_shutdown;
    logic sync_error;
    logic output_overvoltage_trip;
    logic output_undervoltage_trip;
    logic cbc_pair;
  } fault_in_t;
  // rail enables driven out
  typedef struct packed {
    logic mini_buck_en;
    logic aux_ldo_en;
    logic main_buck_en;
  } rail_en_t;
endpackage

/* protection_fault_manager.sv */
// fault response sequencer and byte register map of the regulator
`timescale 1ns/10ps
`include "fault_mgr_defines.svh"
// Function
// - lock-out halts all until both clear
// - mini-buck, LDO, hard thermal faults reset device
// - reset stops rails, blanks, then restarts
// - level 3 faults latch main converter off
// - latched off needs enable low-then-high
// - level 4 faults disable for hiccup time
// - persisting cause repeats hiccup endlessly
// - bad resistor loops validation, never enables
// - resistor loop keeps its cause bit set
// - resistor checked only before bias ready
// - read-only state position register
// - read-only non-interrupt status byte
// - command register resets to zero
// - two masks gate the two cause bytes
// - factory defaults load, others hard-coded
// - voltage code split over two registers
// - current limit register resets all ones
// - aux LDO code register resets 0x30
// - cause bits clear on read if resolved
// - over-current after four detection pairs
// - config bit picks hiccup or latch-off
module protection_fault_manager #(
  parameter int unsigned RESET_BLANK_CYCLES = `RESET_BLANK_CYC,
  parameter int unsigned HICCUP_WAIT_CYCLES = `HICCUP_WAIT_CYC,
  parameter logic [7:0]  FP_IRQ_MASK1       = `RST_IRQ_MASK1,
  parameter logic [7:0]  FP_IRQ_MASK2       = `RST_IRQ_MASK2,
  parameter logic [7:0]  FP_CONFIG1         = `RST_CONFIG1,
  parameter logic [7:0]  FP_CONFIG2         = `RST_CONFIG2,
  parameter logic [7:0]  FP_VOUT_HIGH       = `RST_VOUT_HIGH,
  parameter logic [7:0]  FP_VOUT_LOW        = `RST_VOUT_LOW,
  parameter logic [7:0]  FP_CURRENT_LIMIT_CODE            = `RST_CURRENT_LIMIT_CODE,
  parameter logic [7:0]  FP_AUX_LDO         = `RST_AUX_LDO,
  parameter logic [7:0]  FP_CONFIG4         = `RST_CONFIG4,
  parameter logic [7:0]  FP_CONFIG5         = `RST_CONFIG5
) (
  input  wire logic                      clk_i,
  input  wire logic                      reset_n_i,
  input  wire fault_mgr_pkg::fault_in_t  fault_i,
  input  wire logic                      internal_main_enable_i,
  input  wire logic                      rfreq_valid_i,
  input  wire logic                      rfreq_done_i,
  input  wire logic                      ramp_done_i,
  input  wire logic [7:0]                status_in_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  input  wire logic [3:0]                reg_addr_i,
  input  wire logic [7:0]                reg_wdata_i,
  output logic      [7:0]                reg_rdata_o,
  output fault_mgr_pkg::rail_en_t        rail_en_o,
  output logic      [10:0]               output_voltage_code_o,
  output logic      [7:0]                current_limit_code_o,
  output logic      [5:0]                aux_regulator_voltage_o,
  output logic      [7:0]                command_o,
  output logic                           irq_o
);
  import fault_mgr_pkg::*;

  // ==========================================================
  // registers
  sm_state_t   state_reg;
  sm_state_t   state_next;
  logic [31:0] timer_reg;
  logic [2:0]  ocp_cnt_reg;
  logic        ocp_trip_reg;
  logic        latched_reg;
  logic [7:0]  cause1_reg;
  logic [7:0]  cause2_reg;
  logic [7:0]  cfg_reg [5:15];
  logic [7:0]  rdata_next;
  logic        en_seen_low_reg;

  // ==========================================================
  // fault level decode
  wire lvl1 = fault_i.input_undervoltage_lockout | fault_i.input_overvoltage_lockout;
  wire lvl2 = fault_i.mini_overcurrent | fault_i.mini_overvoltage |
              fault_i.mini_undervoltage | fault_i.aux_ldo_undervoltage |
              fault_i.hard_thermal_shutdown;
  wire uv_latch = cfg_reg[`REG_CONFIG2][`CFG2_UV_LATCH_BIT];
  // configured "latch-off"/"hiccup" option applies to the under-voltage trip and the sync error
  wire lvl3 = (fault_i.output_undervoltage_trip & uv_latch) |
              (fault_i.sync_error & uv_latch) |
              fault_i.output_overvoltage_trip | ocp_trip_reg;
  wire lvl4 = (fault_i.output_undervoltage_trip & ~uv_latch) |
              (fault_i.sync_error & ~uv_latch) |
              fault_i.soft_thermal_shutdown;
  wire timer_zero = (timer_reg == 32'd0);
  wire main_phase = (state_reg == ST_MAIN_EN) | (state_reg == ST_MAIN_RAMP) |
                    (state_reg == ST_MAIN_ON);

  // ==========================================================
  // sequencer: severity priority lvl1 > lvl2 > lvl3 > lvl4
  always_comb begin
    state_next = state_reg;
    if (lvl1) begin
      state_next = ST_NO_POWER;
    end else if (lvl2 && state_reg != ST_BIAS_RESET) begin
      state_next = ST_BIAS_RESET;
    end else begin
      case (state_reg)
        ST_NO_POWER:    state_next = ST_BIAS_INIT;
        ST_BIAS_INIT:   state_next = ST_BIAS_ADDR;
        ST_BIAS_RESET:  if (timer_zero && !lvl2) state_next = ST_BIAS_INIT;
        ST_BIAS_ADDR:   state_next = ST_BIAS_RAMP;
        ST_BIAS_RAMP:   if (ramp_done_i) state_next = ST_RFREQ_CHECK;
        ST_RFREQ_CHECK: if (rfreq_done_i) begin
          state_next = rfreq_valid_i ? ST_BIAS_READY : ST_RFREQ_LOOP;
        end
        // loop re-runs validation, never enabling the main converter
        ST_RFREQ_LOOP:  state_next = ST_RFREQ_CHECK;
        ST_BIAS_READY:  if (internal_main_enable_i && en_seen_low_reg && !lvl3 && !lvl4)
                          state_next = ST_MAIN_EN;
        ST_MAIN_EN:     state_next = ST_MAIN_RAMP;
        ST_MAIN_RAMP,
        ST_MAIN_ON: begin
          if (lvl3) state_next = ST_MAIN_ERROR;
          else if (lvl4) state_next = ST_MAIN_SHUT;
          else if (!internal_main_enable_i) state_next = ST_BIAS_READY;
          else if (state_reg == ST_MAIN_RAMP && ramp_done_i) state_next = ST_MAIN_ON;
        end
        // retry after wait; a lasting cause re-enters the wait from MAIN_RAMP
        ST_MAIN_SHUT:   if (timer_zero) state_next = ST_MAIN_EN;
        ST_MAIN_ERROR:  if (!internal_main_enable_i) state_next = ST_BIAS_READY;
        default:        state_next = ST_NO_POWER;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_NO_POWER;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // blanking and hiccup timer loaded on entry to the waiting state
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_reg <= 32'd0;
    end else if (state_next == ST_BIAS_RESET && state_reg != ST_BIAS_RESET) begin
      timer_reg <= RESET_BLANK_CYCLES - 32'd1;
    end else if (state_next == ST_MAIN_SHUT && state_reg != ST_MAIN_SHUT) begin
      timer_reg <= HICCUP_WAIT_CYCLES - 32'd1;
    end else if (!timer_zero) begin
      timer_reg <= timer_reg - 32'd1;
    end
  end

  // ==========================================================
  // enable edge tracking: only a latch-off needs enable seen low; reset presets it as seen
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_seen_low_reg <= 1'b1;
      latched_reg     <= 1'b0;
    end else begin
      if (state_next == ST_MAIN_ERROR) begin
        latched_reg     <= 1'b1;
        en_seen_low_reg <= 1'b0;
      end else if (!internal_main_enable_i) begin
        latched_reg     <= 1'b0;
        en_seen_low_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // over-current: four detection pairs within the main phase, gaps allowed; count restarts off-phase
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ocp_cnt_reg  <= 3'd0;
      ocp_trip_reg <= 1'b0;
    end else if (!main_phase) begin
      ocp_cnt_reg  <= 3'd0;
      ocp_trip_reg <= 1'b0;
    end else if (fault_i.cbc_pair) begin
      ocp_cnt_reg  <= (ocp_cnt_reg == `OCP_PAIR_COUNT) ? ocp_cnt_reg : ocp_cnt_reg + 3'd1;
      ocp_trip_reg <= (ocp_cnt_reg + 3'd1 >= `OCP_PAIR_COUNT);
    end
  end

  // ==========================================================
  // cause bits: set wins over clear-on-read, clear only when resolved
  wire [7:0] src1 = {1'b0, 1'b0, fault_i.sync_error, state_reg == ST_RFREQ_LOOP,
                     fault_i.hard_thermal_shutdown, fault_i.soft_thermal_shutdown,
                     1'b0, fault_i.input_overvoltage_lockout};
  wire [7:0] src2 = {1'b0, ocp_trip_reg, fault_i.output_overvoltage_trip,
                     fault_i.output_undervoltage_trip, fault_i.aux_ldo_undervoltage,
                     fault_i.mini_overcurrent, fault_i.mini_overvoltage,
                     fault_i.mini_undervoltage};
  wire rd1 = reg_rd_i & (reg_addr_i == `REG_IRQ_CAUSE1);
  wire rd2 = reg_rd_i & (reg_addr_i == `REG_IRQ_CAUSE2);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cause1_reg <= 8'h00;
      cause2_reg <= 8'h00;
    end else begin
      cause1_reg <= src1 | (rd1 ? 8'h00 : cause1_reg);
      cause2_reg <= src2 | (rd2 ? 8'h00 : cause2_reg);
    end
  end

  // ==========================================================
  // writable registers 0x05..0x0F; factory defaults are parameters
  localparam logic [7:0] RST_VAL [5:15] = '{`RST_COMMAND, FP_IRQ_MASK1, FP_IRQ_MASK2,
    FP_CONFIG1, FP_CONFIG2, FP_VOUT_HIGH, FP_VOUT_LOW, FP_CURRENT_LIMIT_CODE, FP_AUX_LDO,
    FP_CONFIG4, FP_CONFIG5};
  genvar gi;
  generate
    for (gi = 5; gi <= 15; gi++) begin : g_cfg
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          cfg_reg[gi] <= RST_VAL[gi];
        end else if (reg_wr_i && reg_addr_i == 4'(gi)) begin
          cfg_reg[gi] <= reg_wdata_i;
        end
      end
    end
  endgenerate

  // ==========================================================
  // read mux; reserved slot reads zero
  always_comb begin
    case (reg_addr_i)
      `REG_STATE_POS:    rdata_next = {4'h0, state_reg};
      `REG_IRQ_CAUSE1:   rdata_next = cause1_reg;
      `REG_IRQ_CAUSE2:   rdata_next = cause2_reg;
      `REG_STATUS_FLAGS: rdata_next = status_in_i;
      `REG_RESERVED:     rdata_next = 8'h00;
      default:           rdata_next = cfg_reg[reg_addr_i];
    endcase
  end

  // ==========================================================
  // outputs, all registered
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o             <= 8'h00;
      rail_en_o               <= '0;
      output_voltage_code_o   <= 11'h000;
      current_limit_code_o    <= 8'h00;
      aux_regulator_voltage_o <= 6'h00;
      command_o               <= 8'h00;
      irq_o                   <= 1'b0;
    end else begin
      if (reg_rd_i) reg_rdata_o <= rdata_next;
      rail_en_o.mini_buck_en  <= (state_next != ST_NO_POWER) &&
                                 (state_next != ST_BIAS_RESET);
      rail_en_o.aux_ldo_en    <= state_next >= ST_BIAS_RAMP && state_next != ST_BIAS_RESET;
      rail_en_o.main_buck_en  <= (state_next == ST_MAIN_RAMP) || (state_next == ST_MAIN_ON);
      output_voltage_code_o   <= {cfg_reg[`REG_VOUT_HIGH], cfg_reg[`REG_VOUT_LOW][7:5]};
      current_limit_code_o    <= cfg_reg[`REG_CURRENT_LIMIT_CODE];
      aux_regulator_voltage_o <= cfg_reg[`REG_AUX_LDO][5:0];
      command_o               <= cfg_reg[`REG_COMMAND];
      irq_o <= |(cause1_reg & ~cfg_reg[`REG_IRQ_MASK1]) |
               |(cause2_reg & ~cfg_reg[`REG_IRQ_MASK2]);
    end
  end

  // ==========================================================
  // assertions
  property p_lockout_halts;
    @(posedge clk_i) disable iff (!reset_n_i) lvl1 |=> state_reg == ST_NO_POWER;
  endproperty
  a_lockout_halts: assert property (p_lockout_halts) else $error("lockout not halted");
  property p_lvl2_reset;
    @(posedge clk_i) disable iff (!reset_n_i) (lvl2 && !lvl1) |=> state_reg == ST_BIAS_RESET;
  endproperty
  a_lvl2_reset: assert property (p_lvl2_reset) else $error("no reset sequence");
  property p_blank_rails_off;
    @(posedge clk_i) disable iff (!reset_n_i)
      state_reg == ST_BIAS_RESET |-> !rail_en_o.mini_buck_en && !rail_en_o.aux_ldo_en;
  endproperty
  a_blank_rails_off: assert property (p_blank_rails_off) else $error("rail on in blank");
  property p_latch_off;
    @(posedge clk_i) disable iff (!reset_n_i)
      (state_reg == ST_MAIN_ERROR && internal_main_enable_i && !lvl1 && !lvl2)
      |=> state_reg == ST_MAIN_ERROR;
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("latch released early");
  property p_no_restart;
    @(posedge clk_i) disable iff (!reset_n_i)
      (state_reg == ST_BIAS_READY && !en_seen_low_reg) |=> state_reg != ST_MAIN_EN;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("restart without toggle");
  property p_hiccup_off;
    @(posedge clk_i) disable iff (!reset_n_i)
      state_reg == ST_MAIN_SHUT |=> !rail_en_o.main_buck_en;
  endproperty
  a_hiccup_off: assert property (p_hiccup_off) else $error("main on in hiccup");
  property p_rfreq_loop;
    @(posedge clk_i) disable iff (!reset_n_i)
      state_reg == ST_RFREQ_LOOP |=> cause1_reg[`CAUSE1_RFREQ_BIT] && !rail_en_o.main_buck_en;
  endproperty
  a_rfreq_loop: assert property (p_rfreq_loop) else $error("rfreq loop wrong");
  property p_ocp_count;
    @(posedge clk_i) disable iff (!reset_n_i)
      (main_phase && fault_i.cbc_pair && ocp_cnt_reg == 3'd3) |=> ocp_trip_reg;
  endproperty
  a_ocp_count: assert property (p_ocp_count) else $error("ocp not declared");
  // the latch-off memory keeps the main converter dark until enable drops
  property p_latch_holds;
    @(posedge clk_i) disable iff (!reset_n_i)
      latched_reg |-> !rail_en_o.main_buck_en;
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("main on while latched");
  property p_blank_restart;
    @(posedge clk_i) disable iff (!reset_n_i)
      (state_reg == ST_BIAS_RESET && timer_zero && !lvl1 && !lvl2)
      |=> rail_en_o.mini_buck_en;
  endproperty
  a_blank_restart: assert property (p_blank_restart) else $error("mini not restarted");
  // each hiccup entry reloads the full wait, so every retry gap is equal
  property p_hiccup_len;
    @(posedge clk_i) disable iff (!reset_n_i)
      ((state_reg == ST_MAIN_RAMP || state_reg == ST_MAIN_ON) &&
       lvl4 && !lvl3 && !lvl1 && !lvl2) |=> timer_reg == HICCUP_WAIT_CYCLES - 32'd1;
  endproperty
  a_hiccup_len: assert property (p_hiccup_len) else $error("hiccup wait not reloaded");
  property p_hiccup_retry;
    @(posedge clk_i) disable iff (!reset_n_i)
      (state_reg == ST_MAIN_SHUT && timer_zero && !lvl1 && !lvl2)
      |=> state_reg == ST_MAIN_EN;
  endproperty
  a_hiccup_retry: assert property (p_hiccup_retry) else $error("no retry after wait");
  property p_rfreq_fail;
    @(posedge clk_i) disable iff (!reset_n_i)
      (state_reg == ST_RFREQ_CHECK && rfreq_done_i && !rfreq_valid_i && !lvl1 && !lvl2)
      |=> state_reg == ST_RFREQ_LOOP;
  endproperty
  a_rfreq_fail: assert property (p_rfreq_fail) else $error("bad resistor accepted");
  // once bias is ready the resistor is not probed again until a lock-out or reset sequence
  property p_no_recheck;
    @(posedge clk_i) disable iff (!reset_n_i)
      (state_reg >= ST_BIAS_READY && !lvl1 && !lvl2)
      |=> state_reg != ST_RFREQ_CHECK && state_reg != ST_RFREQ_LOOP;
  endproperty
  a_no_recheck: assert property (p_no_recheck) else $error("resistor checked again");
  property p_uv_select;
    @(posedge clk_i) disable iff (!reset_n_i)
      (state_reg == ST_MAIN_ON && fault_i.output_undervoltage_trip && !lvl1 && !lvl2 &&
       !fault_i.output_overvoltage_trip && !ocp_trip_reg)
      |=> state_reg == ($past(uv_latch) ? ST_MAIN_ERROR : ST_MAIN_SHUT);
  endproperty
  a_uv_select: assert property (p_uv_select) else $error("wrong uv response");
  // without a read no cause2 bit may drop, whatever its source does
  property p_cause_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      !rd2 |=> &(cause2_reg | ~$past(cause2_reg));
  endproperty
  a_cause_hold: assert property (p_cause_hold) else $error("cause bit lost unread");
endmodule

/* protection_fault_manager_bench.sv */
// self-checking bench of the fault response sequencer and register map
`timescale 1ns/10ps
module protection_fault_manager_bench;
  import fault_mgr_pkg::*;
  typedef struct packed {logic [7:0] d; logic [7:0] m;} exp_t;
  logic        clk_i, reset_n_i, en, rf_ok, rf_done, ramp, wr, rd, irq, rd_seen, main_q;
  logic [7:0]  st_in, rdata, cmd, current_limit_code, seed, rv [16], wv [16];
  logic [10:0] vcode;
  logic [5:0]  aux;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  fault_in_t   flt;
  rail_en_t    rail;
  exp_t        q [$];
  int          fails, num_checks, cyc, rises;
  int          fb [7] = '{4, 3, 1, 0, 2, 3, 1};
  logic [7:0]  cf [7] = '{8'hF3, 8'hF3, 8'hF3, 8'hF3, 8'hF3, 8'hF7, 8'hF7};
  logic        lat [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  int          l2 [5] = '{9, 8, 7, 6, 5};
  time         t0;

  // short blank and hiccup counts keep the run brief
  protection_fault_manager #(.RESET_BLANK_CYCLES(4), .HICCUP_WAIT_CYCLES(8)) DUT (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .fault_i(flt), .internal_main_enable_i(en),
    .rfreq_valid_i(rf_ok), .rfreq_done_i(rf_done), .ramp_done_i(ramp), .status_in_i(st_in),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .rail_en_o(rail), .output_voltage_code_o(vcode),
    .current_limit_code_o(current_limit_code), .aux_regulator_voltage_o(aux), .command_o(cmd),
    .irq_o(irq));

  reg_host host (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata));

  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic end_sim();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic ck(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] m);
    q.push_back('{d, m});
    host.rd(a);
  endtask

  // bounded wait on one rail enable: 2 mini, 1 aux, 0 main
  task automatic wait_rail(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (rail[i] !== v && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    ck(rail[i] === v, "rail enable wait ran out");
  endtask

  // read answers land one edge after the strobe; oldest note is compared
  always @(posedge clk_i) rd_seen <= rd;
  always @(negedge clk_i) begin
    exp_t e;
    if (rd_seen === 1'b1) begin
      e = q.pop_front();
      num_checks++;
      if ((rdata & e.m) !== (e.d & e.m)) begin
        fails++;
        $display("[ERR] %0t read %h expected %h", $time, rdata, e.d);
      end
    end
  end

  // main enable rising edges count retries; cycle ceiling cuts a hang
  always @(posedge clk_i) begin
    main_q <= rail.main_buck_en;
    if (rail.main_buck_en === 1'b1 && main_q === 1'b0) rises++;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end

  initial begin
    reset_n_i = 1'b0;
    en = 1'b0;
    rf_ok = 1'b0;
    rf_done = 1'b1;
    ramp = 1'b1;
    flt = '0;
    st_in = 8'h00;
    seed = 8'h37;
    rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
           8'h28, 8'hF3, 8'h32, 8'h10, 8'hFF, 8'h30, 8'h23, 8'h9E};
    repeat (12) @(negedge clk_i);
    reset_n_i = 1'b1;
    // defaults, with the resistor still refused
    for (int a = 4; a < 16; a++) chk_rd(4'(a), rv[a], 8'hFF);
    ck(rail.main_buck_en === 1'b0, "main on with bad resistor");
    chk_rd(4'h1, 8'h10, 8'h10);
    chk_rd(4'h1, 8'h10, 8'h10);
    ck(irq === 1'b1, "cause did not raise irq");
    host.wr(4'h6, 8'h10);
    repeat (3) @(negedge clk_i);
    ck(irq === 1'b0, "masked cause raised irq");
    // random writes everywhere; status and reserved places keep their meaning
    for (int a = 0; a < 16; a++) begin
      seed = lfsr(seed);
      wv[a] = seed;
      host.wr(4'(a), seed);
    end
    st_in = lfsr(seed);
    for (int a = 3; a < 16; a++)
      chk_rd(4'(a), a == 3 ? st_in : (a == 4 ? 8'h00 : wv[a]), a == 13 ? 8'h3F : 8'hFF);
    ck(vcode === {wv[10], wv[11][7:5]}, "voltage code split");
    ck(current_limit_code === wv[12] && aux === wv[13][5:0] && cmd === wv[5], "register copies");
    for (int a = 5; a < 16; a++) host.wr(4'(a), rv[a]);
    // resistor accepted, then no longer checked once bias is ready
    rf_ok = 1'b1;
    repeat (10) @(negedge clk_i);
    chk_rd(4'h0, 8'h07, 8'hFF);
    rf_ok = 1'b0;
    en = 1'b1;
    wait_rail(0, 1'b1, 50);
    chk_rd(4'h0, 8'h0A, 8'hFF);
    rf_ok = 1'b1;
    // whole-device reset for each level 2 source
    foreach (l2[i]) begin
      flt = fault_in_t'(12'h001 << l2[i]);
      @(negedge clk_i);
      flt = '0;
      wait_rail(2, 1'b0, 10);
      t0 = $time;
      ck(rail === rail_en_t'(3'b000), "rails left on in reset");
      chk_rd(4'h0, 8'h02, 8'hFF);
      wait_rail(2, 1'b1, 40);
      ck(($time - t0) >= 20, "blanking too short");
      wait_rail(0, 1'b1, 100);
    end
    // the four level 2 causes of cause byte 2 stay until read, then clear once resolved
    chk_rd(4'h2, 8'h0F, 8'hFF);
    chk_rd(4'h2, 8'h00, 8'hFF);
    // lock-out wins over a level 3 fault present at the same time
    for (int b = 10; b < 12; b++) begin
      flt = fault_in_t'(12'h004 | (12'h001 << b));
      wait_rail(2, 1'b0, 10);
      repeat (20) @(negedge clk_i);
      ck(rail === rail_en_t'(3'b000), "rails on in lock-out");
      chk_rd(4'h0, 8'h00, 8'hFF);
      flt = fault_in_t'(12'h001 << b);
      @(negedge clk_i);
      flt = '0;
      wait_rail(0, 1'b1, 200);
    end
    // latch-off and hiccup sources under both settings of the response bit
    foreach (fb[i]) begin
      host.wr(4'h9, cf[i]);
      if (fb[i] == 0) begin
        for (int k = 0; k < 4; k++) begin
          flt = fault_in_t'(12'h001);
          @(negedge clk_i);
          flt = '0;
          @(negedge clk_i);
        end
      end else begin
        flt = fault_in_t'(12'h001 << fb[i]);
      end
      wait_rail(0, 1'b0, 10);
      chk_rd(4'h0, lat[i] ? 8'h0C : 8'h0B, 8'hFF);
      if (lat[i]) flt = '0;
      rises = 0;
      repeat (60) @(negedge clk_i);
      ck(lat[i] ? rises == 0 : rises >= 2, "retry count");
      flt = '0;
      if (lat[i]) begin
        if (i == 6) begin
          // a reset sequence must not wipe a pending latch-off
          flt = fault_in_t'(12'h020);
          @(negedge clk_i);
          flt = '0;
          repeat (30) @(negedge clk_i);
          ck(rail === rail_en_t'(3'b110), "restart without enable toggle");
        end
        en = 1'b0;
        repeat (3) @(negedge clk_i);
        chk_rd(4'h0, 8'h07, 8'hFF);
        en = 1'b1;
      end
      wait_rail(0, 1'b1, 100);
    end
    end_sim();
  end
endmodule

/* reg_host_model.sv */
// host model that reaches the byte register port one strobe at a time
`timescale 1ns/10ps
module reg_host (
  input  wire logic       clk_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic [3:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o
);
  // idle bus values, known from time zero
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 4'h0;
    reg_wdata_o = 8'h00;
  end
  // one-cycle write strobe; data inverted afterwards so stale data is never trusted
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask
  // one-cycle read strobe; the bench monitor picks up the answer
  task automatic rd(input logic [3:0] a);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
  endtask
endmodule
